// ==== src/video_port_interrupt_status.sv ====
// video port interrupt status register, enables and interrupt output
//
// Decided for this implementation: the address-and-strobe port and the placing of the registers.
import vp_irq_pkg::*;

// Summary of operation
// - enabled flags only raise the interrupt
// - write one clears flag, zero keeps
// - reserved bits read zero, ignore writes
// - flags zero after reset, reads show state
// - long field: counter passes stop plus one
// - vertical reset select forces long field
// - short field: reset before stop line
// - no field flags in raw, stream, display
// - field two vertical interrupt flag
// - field one vertical interrupt flag
// - sync parity error flag, software resets channel
// - capture done after field or frame
// - raw mode done when frame captured, raw fifo enable clear
// - stream mode done when frame captured
// - overflow flag on fifo overwrite
// - display underflow flag
// - global enable gates every interrupt
module video_port_interrupt_status (
  input  wire logic                  clk,       // 20 MHz clock
  input  wire logic                  arst_n,    // async reset, active low
  input  wire vp_irq_pkg::bus_req_t  bus,       // register bus request
  input  wire vp_irq_pkg::chan_ev_t  ev_b,      // channel B events
  input  wire vp_irq_pkg::chan_ev_t  ev_a,      // channel A events
  input  wire vp_irq_pkg::misc_ev_t  ev_misc,   // display and timing events
  input  wire logic                  display_mode, // port in display mode
  output logic [31:0]                rdata,     // read data, cycle after read
  output logic                       irq        // level interrupt to host
);
  import vp_irq_pkg::*;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // seven flags of one capture channel, msb = long field
  function automatic logic [6:0] chan_flags(input chan_ev_t ev, input logic [1:0] mode,
                                            input logic vertical_reset_select, input logic lfd_en,
                                            input logic sfd_en, input logic raw_fifo_enable,
                                            input logic disp);
    logic field_mode;
    logic long_f;
    logic short_f;
    logic done;
    field_mode = (mode == MODE_656 || mode == MODE_YC) && !disp;
    long_f  = 1'b0;
    short_f = 1'b0;
    done    = 1'b0;
    // counter still running when it hits stop+1
    if (field_mode && lfd_en) begin
      long_f = vertical_reset_select | (!ev.vertical_line_counter_reset && ev.vertical_line_counter == ev.vertical_stop_line + 12'h001);
    end
    if (field_mode && sfd_en && !vertical_reset_select) begin
      short_f = ev.vertical_line_counter_reset && (ev.vertical_line_counter < ev.vertical_stop_line);
    end
    case (mode)
      MODE_656, MODE_YC: done = ev.field_done;
      MODE_RAW:          done = ev.frame_done && !raw_fifo_enable;
      MODE_TS:           done = ev.frame_done;
      default:           done = 1'b0;
    endcase
    chan_flags = {long_f, short_f,
                  field_mode && ev.vert_int && ev.field2,
                  field_mode && ev.vert_int && !ev.field2,
                  field_mode && ev.parity_err,
                  done && !disp,
                  ev.overwrite};
  endfunction

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  irq_state_t st_ff;
  irq_state_t nxt_st;
  logic [31:0] set_vec;
  logic [31:0] clr_vec;
  logic [1:0]  mode;

  always_comb begin
    nxt_st  = st_ff;
    mode    = st_ff.ctrl[CTL_MODE_LO +: 2];
    set_vec = 32'h0000_0000;
    set_vec[CH_B_BASE +: 7] = chan_flags(ev_b, mode, st_ff.ctrl[CTL_VERTICAL_RESET_SELECT_B],
                                         st_ff.ctrl[CTL_LFD_EN], st_ff.ctrl[CTL_SFD_EN],
                                         st_ff.ctrl[CTL_RAW_FIFO_ENABLE], display_mode);
    set_vec[CH_A_BASE +: 7] = chan_flags(ev_a, mode, st_ff.ctrl[CTL_VERTICAL_RESET_SELECT_A],
                                         st_ff.ctrl[CTL_LFD_EN], st_ff.ctrl[CTL_SFD_EN],
                                         st_ff.ctrl[CTL_RAW_FIFO_ENABLE], display_mode);
    set_vec[POS_GPIO] = ev_misc.gpio;
    set_vec[POS_DISPLAY_DONE_UNACKED_FLAG] = ev_misc.done_unacked;
    set_vec[POS_DISPLAY_DONE_FLAG] = ev_misc.done;
    set_vec[POS_DISPLAY_UNDERFLOW_FLAG] = ev_misc.underflow;
    set_vec[POS_TICK] = ev_misc.tick && mode == MODE_TS;
    set_vec[POS_STC]  = ev_misc.time_match && mode == MODE_TS;
    clr_vec = 32'h0000_0000;
    if (bus.wr && bus.addr == ADDR_FLAGS) begin
      clr_vec = bus.wdata;
    end
    // set wins over clear
    nxt_st.flags = ((st_ff.flags & ~clr_vec) | set_vec) & FLAGS_DEFINED;
    if (bus.wr && bus.addr == ADDR_ENABLES) begin
      nxt_st.enables = bus.wdata & (FLAGS_DEFINED | 32'h0000_0001);
    end
    if (bus.wr && bus.addr == ADDR_CTRL) begin
      nxt_st.ctrl = bus.wdata & 32'h0000_007F;
    end
    nxt_st.rdata = 32'h0000_0000;
    if (bus.rd) begin
      case (bus.addr)
        ADDR_FLAGS:   nxt_st.rdata = st_ff.flags;
        ADDR_ENABLES: nxt_st.rdata = st_ff.enables;
        ADDR_CTRL:    nxt_st.rdata = st_ff.ctrl;
        default:      nxt_st.rdata = 32'h0000_0000;
      endcase
    end
    // irq follows the registered flags and enables of the same cycle
    nxt_st.irq = nxt_st.enables[POS_GLOBAL] &&
                 |(nxt_st.flags & nxt_st.enables & FLAGS_DEFINED);
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_ff.flags   <= FLAGS_RESET;
      st_ff.enables <= ENABLES_RESET;
      st_ff.ctrl    <= CTRL_RESET;
      st_ff.rdata   <= 32'h0000_0000;
      st_ff.irq     <= 1'b0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign rdata = st_ff.rdata;
  assign irq   = st_ff.irq;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  chk_irq_gated: assert property (@(posedge clk) disable iff (!arst_n)
    irq |-> |(st_ff.flags & st_ff.enables & FLAGS_DEFINED))
    else $error("interrupt without enabled flag");
  chk_global_gate: assert property (@(posedge clk) disable iff (!arst_n)
    !st_ff.enables[POS_GLOBAL] |-> !irq)
    else $error("interrupt with global enable off");
  chk_reserved_zero: assert property (@(posedge clk) disable iff (!arst_n)
    (st_ff.flags & ~FLAGS_DEFINED) == 32'h0000_0000)
    else $error("reserved flag bit set");
  chk_set_wins: assert property (@(posedge clk) disable iff (!arst_n)
    set_vec[POS_DISPLAY_UNDERFLOW_FLAG] |=> st_ff.flags[POS_DISPLAY_UNDERFLOW_FLAG])
    else $error("underflow event lost");
  chk_clear_one: assert property (@(posedge clk) disable iff (!arst_n)
    (bus.wr && bus.addr == ADDR_FLAGS && set_vec == 32'h0000_0000)
      |=> (st_ff.flags & $past(bus.wdata)) == 32'h0000_0000)
    else $error("write one did not clear");
  chk_zero_keeps: assert property (@(posedge clk) disable iff (!arst_n)
    (bus.wr && bus.addr == ADDR_FLAGS)
      |=> (($past(st_ff.flags) | $past(set_vec)) & ~$past(bus.wdata) & FLAGS_DEFINED)
      == (st_ff.flags & ~$past(bus.wdata)))
    else $error("write zero changed a flag");
  chk_no_field_raw: assert property (@(posedge clk) disable iff (!arst_n)
    (mode == MODE_RAW || mode == MODE_TS || display_mode) |-> set_vec[23:20] == 4'h0)
    else $error("field flag in non field mode");
  chk_read_data: assert property (@(posedge clk) disable iff (!arst_n)
    (bus.rd && bus.addr == ADDR_FLAGS) |=> rdata == $past(st_ff.flags))
    else $error("read data wrong");
  chk_raw_done: assert property (@(posedge clk) disable iff (!arst_n)
    (mode == MODE_RAW && st_ff.ctrl[CTL_RAW_FIFO_ENABLE]) |-> !set_vec[CH_B_BASE + 1])
    else $error("raw done with fifo enable set");
  chk_vertical_reset_select_long: assert property (@(posedge clk) disable iff (!arst_n)
    (mode == MODE_656 && !display_mode && st_ff.ctrl[CTL_VERTICAL_RESET_SELECT_B] && st_ff.ctrl[CTL_LFD_EN])
      |=> st_ff.flags[23])
    else $error("long field not forced");
  chk_long_field: assert property (@(posedge clk) disable iff (!arst_n)
    ((mode == MODE_656 || mode == MODE_YC) && !display_mode && st_ff.ctrl[CTL_LFD_EN]
      && !ev_b.vertical_line_counter_reset && ev_b.vertical_line_counter == ev_b.vertical_stop_line + 12'h001)
      |=> st_ff.flags[23])
    else $error("long field missed");
  chk_short_field: assert property (@(posedge clk) disable iff (!arst_n)
    ((mode == MODE_656 || mode == MODE_YC) && !display_mode && st_ff.ctrl[CTL_SFD_EN]
      && !st_ff.ctrl[CTL_VERTICAL_RESET_SELECT_B] && ev_b.vertical_line_counter_reset && ev_b.vertical_line_counter < ev_b.vertical_stop_line)
      |=> st_ff.flags[22])
    else $error("short field missed");
  chk_vert_two: assert property (@(posedge clk) disable iff (!arst_n)
    ((mode == MODE_656 || mode == MODE_YC) && !display_mode && ev_b.vert_int && ev_b.field2)
      |=> st_ff.flags[21])
    else $error("field two vertical flag missed");
  chk_vert_one: assert property (@(posedge clk) disable iff (!arst_n)
    ((mode == MODE_656 || mode == MODE_YC) && !display_mode && ev_b.vert_int && !ev_b.field2)
      |=> st_ff.flags[20])
    else $error("field one vertical flag missed");
  chk_sync_error: assert property (@(posedge clk) disable iff (!arst_n)
    ((mode == MODE_656 || mode == MODE_YC) && !display_mode && ev_b.parity_err)
      |=> st_ff.flags[19])
    else $error("sync error flag missed");
  chk_field_done: assert property (@(posedge clk) disable iff (!arst_n)
    ((mode == MODE_656 || mode == MODE_YC) && !display_mode && ev_b.field_done)
      |=> st_ff.flags[18])
    else $error("field capture done missed");
  chk_stream_done: assert property (@(posedge clk) disable iff (!arst_n)
    (mode == MODE_TS && !display_mode && ev_b.frame_done) |=> st_ff.flags[18])
    else $error("stream capture done missed");
  chk_overflow_b: assert property (@(posedge clk) disable iff (!arst_n)
    ev_b.overwrite |=> st_ff.flags[CH_B_BASE])
    else $error("channel b overflow missed");
  chk_overflow_a: assert property (@(posedge clk) disable iff (!arst_n)
    ev_a.overwrite |=> st_ff.flags[CH_A_BASE])
    else $error("channel a overflow missed");
  chk_underflow: assert property (@(posedge clk) disable iff (!arst_n)
    ev_misc.underflow |=> st_ff.flags[POS_DISPLAY_UNDERFLOW_FLAG])
    else $error("display underflow missed");
  chk_rdata_idle: assert property (@(posedge clk) disable iff (!arst_n)
    !bus.rd |=> rdata == 32'h0000_0000)
    else $error("read data outside read cycle");

endmodule

// ==== src/vp_irq_pkg.sv ====
// package: offsets, field positions and types of the video port interrupt status block
package vp_irq_pkg;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_FLAGS   = 8'h00;
  localparam logic [7:0] ADDR_ENABLES = 8'h04;
  localparam logic [7:0] ADDR_CTRL    = 8'h08;

  localparam logic [31:0] FLAGS_RESET   = 32'h0000_0000;
  localparam logic [31:0] ENABLES_RESET = 32'h0000_0000;
  // defined flag positions: 23..16, 14..10, 7..1
  localparam logic [31:0] FLAGS_DEFINED = 32'h00FF_7CFE;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int CH_B_BASE   = 17;
  localparam int CH_A_BASE   = 1;
  localparam int POS_GPIO    = 16;
  localparam int POS_DISPLAY_DONE_UNACKED_FLAG    = 14;
  localparam int POS_DISPLAY_DONE_FLAG    = 13;
  localparam int POS_DISPLAY_UNDERFLOW_FLAG    = 12;
  localparam int POS_TICK    = 11;
  localparam int POS_STC     = 10;
  localparam int POS_GLOBAL  = 0;
  // control register fields
  localparam int CTL_MODE_LO = 0;
  localparam int CTL_VERTICAL_RESET_SELECT_B  = 2;
  localparam int CTL_VERTICAL_RESET_SELECT_A  = 3;
  localparam int CTL_LFD_EN  = 4;
  localparam int CTL_SFD_EN  = 5;
  localparam int CTL_RAW_FIFO_ENABLE    = 6;

  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

  // capture modes
  typedef enum logic [1:0] {
    MODE_656     = 2'h0,
    MODE_YC      = 2'h1,
    MODE_RAW     = 2'h2,
    MODE_TS      = 2'h3
  } cap_mode_t;

  // per-channel raw events from the capture datapath
  typedef struct packed {
    logic        vertical_line_counter_reset;  // vertical line counter reset this cycle
    logic [11:0] vertical_line_counter;        // vertical line counter value
    logic [11:0] vertical_stop_line;         // programmed stop line
    logic        field2;        // current field is field 2
    logic        vert_int;      // vertical interrupt point reached
    logic        parity_err;    // timing code parity error
    logic        field_done;    // field/frame captured per control bits
    logic        frame_done;    // data counter reached combined stop value
    logic        overwrite;     // fifo data overwritten before read
  } chan_ev_t;

  typedef struct packed {
    logic        gpio;
    logic        done_unacked;
    logic        done;
    logic        underflow;
    logic        tick;
    logic        time_match;
  } misc_ev_t;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } bus_req_t;

  typedef struct packed {
    logic [31:0] flags;
    logic [31:0] enables;
    logic [31:0] ctrl;
    logic [31:0] rdata;
    logic        irq;
  } irq_state_t;

endpackage

// ==== test/vp_host_model.sv ====
// host model: register bus master beside the interrupt input
module vp_host_model (
  input  wire logic                 clk,   // bus clock
  input  wire logic [31:0]          rdata, // read data
  input  wire logic                 irq,   // interrupt level
  output vp_irq_pkg::bus_req_t      bus    // bus request
);
  timeunit 1ns;
  timeprecision 1ps;
  import vp_irq_pkg::*;
  initial bus = '0;
  task automatic write(input logic [7:0] a, input logic [31:0] w);
    @(posedge clk);
    bus <= '{addr: a, wdata: w, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask
  task automatic read(input logic [7:0] a, output logic [31:0] q);
    @(posedge clk);
    bus <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus.rd <= 1'b0;
    @(negedge clk);
    q = rdata;
  endtask
endmodule

// ==== test/video_port_interrupt_status_test.sv ====
// self-checking bench for the video port interrupt status block
module video_port_interrupt_status_test;
  timeunit 1ns;
  timeprecision 1ps;
  import vp_irq_pkg::*;
  logic        clk;
  logic        arst_n;
  bus_req_t    bus;
  chan_ev_t    ev_b, ev_a, e;
  misc_ev_t    ev_misc, m;
  logic        display_mode;
  logic        irq;
  logic [31:0] rdata, exp_f, exp_en, d, r;
  int          n_mismatch, checked, cycles;

  video_port_interrupt_status video_port_interrupt_status_inst (
    .clk(clk), .arst_n(arst_n), .bus(bus), .ev_b(ev_b), .ev_a(ev_a),
    .ev_misc(ev_misc), .display_mode(display_mode), .rdata(rdata), .irq(irq));
  vp_host_model vp_host_model_inst (.clk(clk), .rdata(rdata), .irq(irq), .bus(bus));

  always #25 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 4000) begin
      n_mismatch++;
      end_of_test();
    end
  end
  // ----
  // helpers
  // ----
  function automatic logic exp_irq(input logic [31:0] f, input logic [31:0] en);
    return en[POS_GLOBAL] & (|(f & en & FLAGS_DEFINED));
  endfunction
  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: word %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_irq(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: irq %b expected %b", $time, got, exp);
    end
  endtask
  task automatic check_state();
    vp_host_model_inst.read(ADDR_FLAGS, d);
    cmp_word(d, exp_f);
    cmp_irq(irq, exp_irq(exp_f, exp_en));
  endtask
  task automatic pulse(input chan_ev_t b, input chan_ev_t a, input misc_ev_t x);
    @(posedge clk);
    ev_b <= b;
    ev_a <= a;
    ev_misc <= x;
    @(posedge clk);
    ev_b <= '0;
    ev_a <= '0;
    ev_misc <= '0;
  endtask
  task automatic field_case(input logic [31:0] ctl, input logic disp, input logic [11:0] vc,
                            input logic rst, input logic [31:0] expm);
    vp_host_model_inst.write(ADDR_CTRL, ctl);
    vp_host_model_inst.write(ADDR_FLAGS, 32'hFFFF_FFFF);
    display_mode <= disp;
    e = '0;
    e.vertical_stop_line = 12'h064;
    e.vertical_line_counter = vc;
    e.vertical_line_counter_reset = rst;
    e.frame_done = ctl[1];
    e.vert_int = ctl[1];
    pulse(e, '0, '0);
    exp_f = expm;
    check_state();
  endtask
  task automatic end_of_test();
    $display("checked %0d n_mismatch %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // ----
  // main sequence
  // ----
  initial begin
    void'($urandom(32'ha3a9));
    clk = 1'b0;
    arst_n = 1'b0;
    ev_b = '0;
    ev_a = '0;
    ev_misc = '0;
    display_mode = 1'b0;
    exp_f = FLAGS_RESET;
    exp_en = ENABLES_RESET;
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    check_state();
    vp_host_model_inst.read(8'h0C, d);
    cmp_word(d, 32'h0000_0000);
    e = '0;
    m = '0;
    e.vert_int = 1'b1;
    pulse(e, e, m);
    exp_f |= 32'h0010_0010;
    e.field2 = 1'b1;
    pulse(e, e, m);
    exp_f |= 32'h0020_0020;
    check_state();
    e = '0;
    e.parity_err = 1'b1;
    e.field_done = 1'b1;
    e.overwrite = 1'b1;
    m.underflow = 1'b1;
    pulse(e, e, m);
    exp_f |= 32'h000E_100E;
    check_state();
    for (int i = 0; i < 24; i++) begin
      r = $urandom;
      e = '0;
      m = '0;
      e.parity_err = r[0];
      e.field_done = r[1];
      e.overwrite = r[2];
      m.underflow = r[3];
      pulse(e, e, m);
      exp_f |= {12'h000, r[0], r[1], r[2], 4'h0, r[3], 8'h00, r[0], r[1], r[2], 1'b0};
      exp_en = $urandom;
      vp_host_model_inst.write(ADDR_ENABLES, exp_en);
      vp_host_model_inst.read(ADDR_ENABLES, d);
      cmp_word(d, exp_en & (FLAGS_DEFINED | 32'h0000_0001));
      check_state();
      r = ($urandom & $urandom) | 32'hFF00_8301;
      vp_host_model_inst.write(ADDR_FLAGS, r);
      exp_f &= ~r;
      check_state();
    end
    exp_en = 32'h00FF_7CFF;
    vp_host_model_inst.write(ADDR_ENABLES, exp_en);
    field_case(32'h0000_0030, 1'b0, 12'h065, 1'b0, 32'h0080_0000);
    field_case(32'h0000_0030, 1'b0, 12'h063, 1'b1, 32'h0040_0000);
    field_case(32'h0000_0030, 1'b0, 12'h064, 1'b1, 32'h0000_0000);
    field_case(32'h0000_0034, 1'b0, 12'h010, 1'b1, 32'h0080_0000);
    field_case(32'h0000_0032, 1'b0, 12'h065, 1'b0, 32'h0004_0000);
    field_case(32'h0000_0033, 1'b0, 12'h063, 1'b1, 32'h0004_0000);
    field_case(32'h0000_0030, 1'b1, 12'h065, 1'b0, 32'h0000_0000);
    field_case(32'h0000_0072, 1'b0, 12'h065, 1'b0, 32'h0000_0000);
    display_mode <= 1'b0;
    m = '1;
    vp_host_model_inst.write(ADDR_CTRL, 32'h0000_0003);
    vp_host_model_inst.write(ADDR_FLAGS, 32'hFFFF_FFFF);
    pulse('0, '0, m);
    exp_f = 32'h0001_7C00;
    check_state();
    vp_host_model_inst.write(ADDR_CTRL, 32'h0000_0000);
    vp_host_model_inst.write(ADDR_FLAGS, 32'hFFFF_FFFF);
    pulse('0, '0, m);
    exp_f = 32'h0001_7000;
    check_state();
    vp_host_model_inst.write(ADDR_FLAGS, 32'hFFFF_FFFF);
    vp_host_model_inst.write(ADDR_CTRL, 32'h0000_0000);
    e = '0;
    e.overwrite = 1'b1;
    pulse(e, '0, '0);
    fork
      vp_host_model_inst.write(ADDR_FLAGS, 32'h0002_0000);
      pulse(e, '0, '0);
    join
    exp_f = 32'h0002_0000;
    check_state();
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    exp_f = FLAGS_RESET;
    exp_en = ENABLES_RESET;
    check_state();
    vp_host_model_inst.read(ADDR_ENABLES, d);
    cmp_word(d, ENABLES_RESET);
    end_of_test();
  end
endmodule
